// ==== parallel_flash_bus_operations_tb_top.sv ====
// Self-checking bench for the flash bus controller
`timescale 1ns/1ps
`include "pfc_defs.svh"
module parallel_flash_bus_operations_tb_top;
    typedef struct {logic [19:0] a; logic [15:0] d; logic w; logic [4:0] s;} pfc_row_t;
    pfc_row_t rows[7] = '{
        '{20'h00000, 16'h1234, 1'b1, 5'd0}, '{20'h10000, 16'h5aa5, 1'b1, 5'd1},
        '{20'heffff, 16'habcd, 1'b1, 5'd14}, '{20'hf0001, 16'h0055, 1'b0, 5'd15},
        '{20'hf8000, 16'h00a6, 1'b0, 5'd16}, '{20'hfa003, 16'h0071, 1'b0, 5'd17},
        '{20'hfffff, 16'h00c3, 1'b0, 5'd18}};
    logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, t = 1'b0, sn, gn, stn, cn, wd, rb;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [18:0] fa;
    logic [15:0] cdo, coe, mdo, moe, dq;
    int num_errors = 0, checked = 0;
    always #5 clk = ~clk;
    always @(posedge clk) t <= ~t;
    // Undriven lines toggle so a stale value never passes
    assign dq = (coe & cdo) | (~coe & moe & mdo) | (~coe & ~moe & {16{t}});
    pfc_ctrl pfc_ctrl_inst (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .FL_ADDR_O(fa), .FL_DQ_I(dq),
        .FL_DQ_O(cdo), .FL_DQ_OE_O(coe), .FL_SEL_N_O(sn), .FL_GATE_N_O(gn),
        .FL_STROBE_N_O(stn), .FL_CLEAR_N_O(cn), .FL_WORD_O(wd), .FL_READY_BUSY_I(rb));
    pfc_flash_model pfc_flash_model_inst (.addr_i(fa), .dq_i(dq), .sel_n_i(sn),
        .gate_n_i(gn), .strobe_n_i(stn), .clear_n_i(cn), .word_i(wd), .dq_o(mdo),
        .dq_oe_o(moe), .ready_o(rb));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] r);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 r = rdata;
    endtask
    task automatic op(input logic [7:0] c, input logic w);
        logic [31:0] s;
        wr(`PFC_REG_CTRL, {16'h0, c, 7'h0, w});
        for (int i = 0; i < 300; i++) begin
            rd(`PFC_REG_STATUS, s);
            if (s[0] === 1'b0) return;
        end
        chk("busy wait", 32'h0, 32'h1);
    endtask
    task automatic summarize();
        if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        if (!rst) begin
            if (!sn && !gn) chk("strobe in read", 32'h1, {31'h0, stn});
            if (!stn) chk("gate in write", 32'h1, {31'h0, gn});
            if (!wd) chk("byte lanes", 32'h0, {25'h0, coe[14:8]});
        end
    end
    // Scenarios need a few hundred cycles; 20000 leaves ample margin
    initial begin
        #200_000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk("idle pins", 32'h7, {29'h0, sn, cn, wd});
        chk("rdata reset", 32'h0, rdata);
        wr(`PFC_REG_ADDR, 32'h2468a);
        op(`PFC_CMD_READ, 1'b1);
        rd(`PFC_REG_RDATA, v);
        chk("unwritten", 32'hcdcc, v);
        rd(4'hf, v);
        chk("unmapped", 32'h0, v);
        foreach (rows[i]) begin
            wr(`PFC_REG_ADDR, {12'h0, rows[i].a});
            rd(`PFC_REG_SECTOR, v);
            chk("sector", {27'h0, rows[i].s}, v);
            wr(`PFC_REG_WDATA, {16'h0, rows[i].d});
            op(`PFC_CMD_WRITE, rows[i].w);
            op(`PFC_CMD_READ, rows[i].w);
            rd(`PFC_REG_RDATA, v);
            chk("read back", {16'h0, rows[i].w ? rows[i].d : {8'h0, rows[i].d[7:0]}}, v);
        end
        wr(`PFC_REG_ADDR, 32'h30000);
        wr(`PFC_REG_WDATA, 32'h0bad);
        wr(`PFC_REG_CTRL, {16'h0, `PFC_CMD_WRITE, 8'h1});
        wr(`PFC_REG_CTRL, {16'h0, `PFC_CMD_CLEAR, 8'h1});
        op(8'h0, 1'b1);
        rd(`PFC_REG_STATUS, v);
        chk("clear while busy", 32'h0, {31'h0, v[2]});
        wr(`PFC_REG_CTRL, {16'h0, `PFC_CMD_CLEAR, 8'h1});
        repeat (3) @(posedge clk);
        #1 chk("clear pins", 32'h0, {15'h0, cn, coe});
        rd(`PFC_REG_STATUS, v);
        chk("ready low in clear", 32'h1, {29'h0, v[2:0]});
        op(8'h0, 1'b1);
        rd(`PFC_REG_STATUS, v);
        chk("cleared", 32'h6, {29'h0, v[2:0]});
        op(`PFC_CMD_READ, 1'b1);
        rd(`PFC_REG_RDATA, v);
        chk("after clear", 32'h0bad, v);
        // Reset in the middle of a byte read drops every pin to idle
        wr(`PFC_REG_CTRL, {16'h0, `PFC_CMD_READ, 8'h0});
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk("reset pins", 32'h001f0000, {11'h0, sn, gn, stn, cn, wd, coe});
        rd(`PFC_REG_STATUS, v);
        chk("reset status", 32'h2, v);
        rd(`PFC_REG_CTRL, v);
        chk("reset width", 32'h1, v);
        summarize();
    end
endmodule // parallel_flash_bus_operations_tb_top

// ==== pfc_ctrl.sv ====
// Host controller driving an asynchronous parallel flash through its pins
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "pfc_defs.svh"
module pfc_ctrl import pfc_pkg::*; #(
    parameter pfc_boot_t BOOT = PFC_BOOT_TOP,
    parameter int ACCESS_CYC = `PFC_ACCESS_CYC,
    parameter int SETUP_CYC = `PFC_SETUP_CYC,
    parameter int CLRPULSE_CYC = `PFC_CLRPULSE_CYC,
    parameter int CLR2READ_CYC = `PFC_CLR2READ_CYC
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // Register port
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    // Flash pins
    output logic [18:0] FL_ADDR_O,
    input wire logic [15:0] FL_DQ_I,
    output logic [15:0] FL_DQ_O,
    output logic [15:0] FL_DQ_OE_O,
    output logic FL_SEL_N_O,
    output logic FL_GATE_N_O,
    output logic FL_STROBE_N_O,
    output logic FL_CLEAR_N_O,
    output logic FL_WORD_O,
    input wire logic FL_READY_BUSY_I
);
    localparam int CW = 8;
    pfc_state_t state_ff, nxt_state;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [19:0] addr_ff, nxt_addr;
    logic [15:0] wdata_ff, nxt_wdata;
    logic [15:0] rdata_ff, nxt_rdata;
    logic word_ff, nxt_word;
    logic busy_ff, nxt_busy;
    logic cleared_ff, nxt_cleared;
    logic [31:0] rdout_ff, nxt_rdout;
    logic [2:0] rb_sync_ff, nxt_rb_sync;
    logic rb_ff, nxt_rb;
    logic [4:0] sector;

    // Ready flag: three stages, accept change when last two agree
    always_comb begin
        nxt_rb_sync = {rb_sync_ff[1:0], FL_READY_BUSY_I};
        nxt_rb = rb_ff;
        // A lone sample on the middle stage may still be settling
        if (rb_sync_ff[2] == rb_sync_ff[1]) begin
            nxt_rb = rb_sync_ff[2];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rb_sync_ff <= 3'h7;
            rb_ff <= 1'b1;
        end else begin
            rb_sync_ff <= nxt_rb_sync;
            rb_ff <= nxt_rb;
        end
    end

    // Sector from the high address bits of the byte address
    always_comb begin
        sector = {1'b0, addr_ff[19:16]};
        if (BOOT == PFC_BOOT_TOP) begin
            if (addr_ff[19:16] == 4'hf) begin
                if (!addr_ff[15]) begin
                    sector = 5'd15;
                end else if (addr_ff[14:13] == 2'h0) begin
                    sector = 5'd16;
                end else if (addr_ff[14:13] == 2'h1) begin
                    sector = 5'd17;
                end else begin
                    sector = 5'd18;
                end
            end
        end else begin
            sector = {1'b0, addr_ff[19:16]} + 5'd3;
            if (addr_ff[19:16] == 4'h0) begin
                if (!addr_ff[15]) begin
                    sector = addr_ff[14] ? (addr_ff[13] ? 5'd2 : 5'd1) : 5'd0;
                end else begin
                    sector = 5'd3;
                end
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_rdata = rdata_ff;
        nxt_word = word_ff;
        nxt_busy = busy_ff;
        nxt_cleared = cleared_ff;
        nxt_rdout = 32'h0;
        if (WR_I) begin
            case (ADDR_I)
                `PFC_REG_CTRL: begin
                    // Width must not change under a running transfer
                    if (!busy_ff) begin
                        nxt_word = WDATA_I[`PFC_CTRL_WORD];
                    end
                end
                `PFC_REG_ADDR: nxt_addr = WDATA_I[19:0];
                `PFC_REG_WDATA: nxt_wdata = WDATA_I[15:0];
                default: ;
            endcase
        end
        if (RD_I) begin
            case (ADDR_I)
                `PFC_REG_CTRL: nxt_rdout = {31'h0, word_ff};
                `PFC_REG_ADDR: nxt_rdout = {12'h0, addr_ff};
                `PFC_REG_WDATA: nxt_rdout = {16'h0, wdata_ff};
                `PFC_REG_RDATA: nxt_rdout = {16'h0, rdata_ff};
                `PFC_REG_STATUS: nxt_rdout = {29'h0, cleared_ff, rb_ff, busy_ff};
                `PFC_REG_SECTOR: nxt_rdout = {27'h0, sector};
                default: nxt_rdout = 32'h0;
            endcase
        end
        case (state_ff)
            PFC_IDLE: begin
                if (WR_I && ADDR_I == `PFC_REG_CTRL && !busy_ff) begin
                    nxt_busy = 1'b1;
                    nxt_cnt = '0;
                    if (WDATA_I[15:8] == `PFC_CMD_READ) begin
                        nxt_state = PFC_RD;
                    end else if (WDATA_I[15:8] == `PFC_CMD_WRITE) begin
                        nxt_state = PFC_WR_SETUP;
                    end else if (WDATA_I[15:8] == `PFC_CMD_CLEAR) begin
                        nxt_state = PFC_CLR;
                        nxt_cleared = 1'b0;
                    end else begin
                        nxt_busy = 1'b0;
                    end
                end
            end
            PFC_RD: begin
                // Access from select low also covers leaving standby
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == CW'(ACCESS_CYC)) begin
                    nxt_rdata = word_ff ? FL_DQ_I : {8'h0, FL_DQ_I[7:0]};
                    nxt_state = PFC_IDLE;
                    nxt_busy = 1'b0;
                end
            end
            PFC_WR_SETUP: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == CW'(SETUP_CYC - 1)) begin
                    nxt_cnt = '0;
                    nxt_state = PFC_WR_HOLD;
                end
            end
            PFC_WR_HOLD: begin
                nxt_state = PFC_IDLE;
                nxt_busy = 1'b0;
            end
            PFC_CLR: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == CW'(CLRPULSE_CYC - 1)) begin
                    nxt_cnt = '0;
                    nxt_state = PFC_CLR_WAIT;
                end
            end
            PFC_CLR_WAIT: begin
                // Hold off until ready returns and read delay passed
                if (!rb_ff) begin
                    nxt_cnt = '0;
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
                if (rb_ff && cnt_ff == CW'(CLR2READ_CYC - 1)) begin
                    nxt_state = PFC_IDLE;
                    nxt_busy = 1'b0;
                    nxt_cleared = 1'b1;
                end
            end
            default: nxt_state = PFC_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_ff <= PFC_IDLE;
            cnt_ff <= '0;
            addr_ff <= 20'h0;
            wdata_ff <= 16'h0;
            rdata_ff <= 16'h0;
            word_ff <= 1'b1;
            busy_ff <= 1'b0;
            cleared_ff <= 1'b0;
            rdout_ff <= 32'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            rdata_ff <= nxt_rdata;
            word_ff <= nxt_word;
            busy_ff <= nxt_busy;
            cleared_ff <= nxt_cleared;
            rdout_ff <= nxt_rdout;
        end
    end

    // Pin drive; select released when idle gives standby
    logic drv;
    assign drv = (state_ff == PFC_WR_SETUP) || (state_ff == PFC_WR_HOLD);
    assign RDATA_O = rdout_ff;
    assign FL_SEL_N_O = !(state_ff == PFC_RD || state_ff == PFC_WR_SETUP);
    assign FL_GATE_N_O = (state_ff != PFC_RD);
    assign FL_STROBE_N_O = (state_ff != PFC_WR_SETUP);
    assign FL_CLEAR_N_O = (state_ff != PFC_CLR);
    assign FL_WORD_O = word_ff;
    assign FL_ADDR_O = word_ff ? addr_ff[19:1] : addr_ff[19:1];
    assign FL_DQ_O = word_ff ? wdata_ff : {addr_ff[0], 7'h0, wdata_ff[7:0]};
    assign FL_DQ_OE_O = word_ff ? {16{drv}} : {state_ff != PFC_CLR, 7'h0, {8{drv}}};

    property p_read_gate;
        @(posedge CLK_I) disable iff (RST_I)
        !FL_GATE_N_O |-> (!FL_SEL_N_O && FL_STROBE_N_O && FL_DQ_OE_O[7:0] == 8'h0);
    endproperty
    a_read_gate: assert property (p_read_gate) else $error("read pins wrong");
    property p_write_pins;
        @(posedge CLK_I) disable iff (RST_I)
        !FL_STROBE_N_O |-> (!FL_SEL_N_O && FL_GATE_N_O);
    endproperty
    a_write_pins: assert property (p_write_pins) else $error("write pins wrong");
    property p_clr_len;
        @(posedge CLK_I) disable iff (RST_I)
        $fell(FL_CLEAR_N_O) |-> !FL_CLEAR_N_O [*8];
    endproperty
    a_clr_len: assert property (p_clr_len) else $error("clear pulse too short");
    property p_clr_idle;
        @(posedge CLK_I) disable iff (RST_I)
        !FL_CLEAR_N_O |-> FL_SEL_N_O && FL_STROBE_N_O;
    endproperty
    a_clr_idle: assert property (p_clr_idle) else $error("access during clear");

    // Low-time counts of clear, gate and strobe, for the length checks
    logic [CW-1:0] clr_len_ff, nxt_clr_len;
    logic [CW-1:0] rd_len_ff, nxt_rd_len;
    logic [CW-1:0] wr_len_ff, nxt_wr_len;
    always_comb begin
        nxt_clr_len = '0;
        nxt_rd_len = '0;
        nxt_wr_len = '0;
        // Saturate so a long pulse never wraps below the minimum
        if (!FL_CLEAR_N_O) begin
            nxt_clr_len = (clr_len_ff == '1) ? clr_len_ff : clr_len_ff + 1'b1;
        end
        if (!FL_GATE_N_O) begin
            nxt_rd_len = (rd_len_ff == '1) ? rd_len_ff : rd_len_ff + 1'b1;
        end
        if (!FL_STROBE_N_O) begin
            nxt_wr_len = (wr_len_ff == '1) ? wr_len_ff : wr_len_ff + 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            clr_len_ff <= '0;
            rd_len_ff <= '0;
            wr_len_ff <= '0;
        end else begin
            clr_len_ff <= nxt_clr_len;
            rd_len_ff <= nxt_rd_len;
            wr_len_ff <= nxt_wr_len;
        end
    end

    property p_clr_min;
        @(posedge CLK_I) disable iff (RST_I)
        $rose(FL_CLEAR_N_O) |-> clr_len_ff >= CW'(CLRPULSE_CYC);
    endproperty
    a_clr_min: assert property (p_clr_min) else $error("clear pulse under minimum");
    property p_read_access;
        @(posedge CLK_I) disable iff (RST_I)
        $rose(FL_GATE_N_O) |-> rd_len_ff >= CW'(ACCESS_CYC);
    endproperty
    a_read_access: assert property (p_read_access) else $error("read too early");
    property p_write_setup;
        @(posedge CLK_I) disable iff (RST_I)
        $rose(FL_STROBE_N_O) |-> wr_len_ff >= CW'(SETUP_CYC);
    endproperty
    a_write_setup: assert property (p_write_setup) else $error("strobe too short");
    property p_write_hold;
        @(posedge CLK_I) disable iff (RST_I)
        $rose(FL_STROBE_N_O) |-> FL_DQ_OE_O[7:0] == 8'hff;
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("data released early");
    property p_wait_ready;
        @(posedge CLK_I) disable iff (RST_I)
        (state_ff == PFC_CLR_WAIT && !rb_ff) |=> state_ff == PFC_CLR_WAIT;
    endproperty
    a_wait_ready: assert property (p_wait_ready) else $error("left clear while busy");
    property p_byte_lanes;
        @(posedge CLK_I) disable iff (RST_I)
        !FL_WORD_O |-> FL_DQ_OE_O[14:8] == 7'h0;
    endproperty
    a_byte_lanes: assert property (p_byte_lanes) else $error("byte lanes driven");
    property p_read_float;
        @(posedge CLK_I) disable iff (RST_I)
        (!FL_GATE_N_O && FL_WORD_O) |-> FL_DQ_OE_O == 16'h0;
    endproperty
    a_read_float: assert property (p_read_float) else $error("word read driven");
endmodule // pfc_ctrl

// ==== pfc_defs.svh ====
// Register offsets, field positions and timing counts for the flash bus controller
// What this block does
// - Read: select and gate low, strobe high.
// - Write: strobe and select low, gate high.
// - Idle clear, then wait before reading.
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH
`define PFC_CLK_NS 10
`define PFC_REG_CTRL 4'h0
`define PFC_REG_ADDR 4'h1
`define PFC_REG_WDATA 4'h2
`define PFC_REG_RDATA 4'h3
`define PFC_REG_STATUS 4'h4
`define PFC_REG_SECTOR 4'h5
`define PFC_CTRL_WORD 0
`define PFC_CTRL_CLEAR 1
`define PFC_CMD_READ 8'h01
`define PFC_CMD_WRITE 8'h02
`define PFC_CMD_CLEAR 8'h03
`define PFC_ACCESS_NS 90
`define PFC_SETUP_NS 60
`define PFC_CLRPULSE_NS 500
`define PFC_CLR2READ_NS 50
`define PFC_ACCESS_CYC ((`PFC_ACCESS_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_SETUP_CYC ((`PFC_SETUP_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CLRPULSE_CYC ((`PFC_CLRPULSE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CLR2READ_CYC ((`PFC_CLR2READ_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`endif

// ==== pfc_flash_model.sv ====
// Behavioural parallel flash device for the controller bench
`timescale 1ns/1ps
module pfc_flash_model #(
    parameter int ACC_NS = 80,
    parameter int RDY_NS = 700
) (
    // Pins from the host
    input wire logic [18:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic sel_n_i,
    input wire logic gate_n_i,
    input wire logic strobe_n_i,
    input wire logic clear_n_i,
    input wire logic word_i,
    // Pins to the host
    output logic [15:0] dq_o,
    output logic [15:0] dq_oe_o,
    output logic ready_o
);
    logic [7:0] mem [logic [19:0]];
    logic [19:0] ba;
    logic [19:0] lat_a;
    logic wr_act = 1'b0;
    logic wr_lvl;
    logic ready_r = 1'b1;
    logic rd_en;
    logic rd_ok;
    assign ba = word_i ? {addr_i, 1'b0} : {addr_i, dq_i[15]};
    assign rd_en = !sel_n_i && !gate_n_i && clear_n_i;
    // Inertial delay: data only after the select access time
    assign #(ACC_NS) rd_ok = rd_en;
    assign ready_o = ready_r;
    assign wr_lvl = !strobe_n_i && !sel_n_i;
    assign dq_oe_o = !(rd_en && rd_ok) ? 16'h0 : word_i ? 16'hffff : 16'h00ff;
    function automatic logic [7:0] rdb(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8];
    endfunction
    always @(ba or rd_en or word_i) begin
        dq_o = word_i ? {rdb(ba | 20'h1), rdb(ba)} : {8'h0, rdb(ba)};
    end
    // One process owns the write latch, so clear and strobes cannot race
    always @(wr_lvl or clear_n_i) begin
        if (!clear_n_i) begin
            wr_act = 1'b0;
        end else if (wr_lvl && !wr_act && gate_n_i) begin
            wr_act = 1'b1;
            lat_a = ba;
        end else if (!wr_lvl && wr_act) begin
            wr_act = 1'b0;
            mem[lat_a] = dq_i[7:0];
            if (word_i) begin
                mem[lat_a | 20'h1] = dq_i[15:8];
            end
        end
    end
    // Every clear reads as busy for a while, so the host has to wait
    always @(negedge clear_n_i) begin
        ready_r = 1'b0;
        #(RDY_NS);
        ready_r = 1'b1;
    end
endmodule // pfc_flash_model

// ==== pfc_pkg.sv ====
// Types for the flash bus controller
package pfc_pkg;
    typedef enum logic [2:0] {
        PFC_IDLE, PFC_RD, PFC_WR_SETUP, PFC_WR_HOLD, PFC_CLR, PFC_CLR_WAIT
    } pfc_state_t;
    typedef enum logic {PFC_BOOT_TOP, PFC_BOOT_BOTTOM} pfc_boot_t;
endpackage
